// ==== monitor_conversion_control_map.svh ====
`ifndef MONITOR_CONVERSION_CONTROL_MAP_SVH
`define MONITOR_CONVERSION_CONTROL_MAP_SVH

// Register pointers.
`define VCFG_OFS 8'h00
`define TCFG_OFS 8'h01

// Reset values and write masks.
`define VCFG_RST 16'h399f
`define TCFG_RST_TRIPLE 16'hff80
`define TCFG_RST_DUAL 16'hbf80
`define VCFG_WMASK 16'h3fff
`define TCFG_WMASK 16'hff83

// Voltage configuration fields.
`define VC_RST_BIT 15
`define VC_ONESHOT_BIT 14
`define VC_RANGE_BIT 13
`define VC_GAIN_HI 12
`define VC_GAIN_LO 11
`define VC_BUS_HI 10
`define VC_BUS_LO 7
`define VC_SHUNT_HI 6
`define VC_SHUNT_LO 3
`define VC_MODE_HI 2
`define VC_MODE_LO 0

// Temperature configuration fields.
`define TC_REPEAT_BIT 15
`define TC_RMT3_BIT 14
`define TC_RMT2_BIT 13
`define TC_RMT1_BIT 12
`define TC_LOC_BIT 11
`define TC_SRF_BIT 10
`define TC_RATE_HI 9
`define TC_RATE_LO 7
`define TC_PIN_BIT 2
`define TC_DRV_HI 1
`define TC_DRV_LO 0

// Operating mode codes.
`define MODE_PD 3'h0
`define MODE_OFF 3'h4

// Timing: clock period and the microsecond tick.
`define CLK_PERIOD_NS 25
`define TICK_NS 1000

// Conversion times in microseconds.
`define T9B_US 18'h00069
`define T10B_US 18'h000b9
`define T11B_US 18'h00159
`define T12B_US 18'h00299
`define TAVG2_US 18'h00514
`define TAVG4_US 18'h00a14
`define TAVG8_US 18'h0140a
`define TAVG16_US 18'h0280a
`define TAVG32_US 18'h0500a
`define TAVG64_US 18'h0a00a
`define TAVG128_US 18'h14000

// Temperature periods in microseconds: 8, 4, 2 and 2/3, 2 per second.
`define RATE8_US 24'h01e848
`define RATE4_US 24'h03d090
`define RATE3_US 24'h05b8d8
`define RATE2_US 24'h07a120
`define RATE_FAST 3'h7
`define RATE_HALF 3'h6

`endif

// ==== monitor_conversion_control_pkg.sv ====
`default_nettype none
package monitor_conversion_control_pkg;
  typedef enum logic [6:0] {
    SER_IDLE = 7'h01,
    SER_ADDR = 7'h02,
    SER_AACK = 7'h04,
    SER_WBYTE = 7'h08,
    SER_WACK = 7'h10,
    SER_RBYTE = 7'h20,
    SER_RACK = 7'h40
  } ser_state_e;
  typedef enum logic [2:0] {
    V_OFF = 3'h1,
    V_IDLE = 3'h2,
    V_CONV = 3'h4
  } volt_state_e;
  typedef enum logic [1:0] {
    T_OFF = 2'h1,
    T_RUN = 2'h2
  } temp_state_e;
endpackage
`default_nettype wire

// ==== sync_filter.sv ====
`default_nettype none
// Three-stage input synchroniser; a change is taken once stages two and three agree.
module sync_filter #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Levels
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_d;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= rawIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end
endmodule // sync_filter
`default_nettype wire

// ==== monitor_conversion_control.sv ====
// Summary of operation
// - 16-bit registers move as two bytes
// - Reset bit restores defaults, self-clears
// - One-shot bit launches one measurement
// - Bit 13 picks 16V or 32V range
// - Bits 12:11 set shunt gain, default 11
// - Bits 10:7 bus resolution or averaging
// - Bits 6:3 shunt resolution or averaging
// - Four-bit field: bits or sample count
// - Conversion time follows the field setting
// - Bits 2:0 select operating mode
// - Mode 000 halts converter at once
// - Mode 100 finishes conversion, then stops
// - Triggered modes idle until one-shot or temperature
// - No channels, not continuous: stop now
// - Not continuous: finish enabled pass, stop
// - Continuous bit repeats temperature passes
// - One-shot starts one temperature pass
// - Bits 14:12 enable remote channels 3..1
// - Bit 11 enables local channel
// - Bit 10 enables resistance correction
// - Bits 9:7 set temperature rate
// - Fastest rates slow with more channels
// - Temperature core paces triggered voltage conversions, except at the fastest rate (7)
// - Pin drive field and pin read-back
`include "monitor_conversion_control_map.svh"
`default_nettype none
module monitor_conversion_control #(
  parameter logic [6:0] DEV_ADDR = 7'h5c,
  parameter bit THREE_CH = 1'b1,
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Two-wire serial link
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // General-purpose pin
  input wire logic gpioIn,
  output logic gpioOut,
  output logic gpioOe,
  // Voltage core controls
  output logic busRangeSelect,
  output logic [1:0] gainSelect,
  output logic [3:0] busSampleCfg,
  output logic [3:0] shuntSampleCfg,
  output logic voltBusy,
  output logic voltDone,
  // Temperature core controls
  output logic [3:0] tempChannelOn,
  output logic seriesResistanceFix,
  output logic tempBusy,
  output logic tempDone
);
  localparam logic [15:0] TCFG_RST = THREE_CH ? `TCFG_RST_TRIPLE : `TCFG_RST_DUAL;

  logic [2:0] level;
  logic sclF, sdaF, pinF;

  sync_filter #(.WIDTH(3), .INIT(3'h3)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .rawIn({gpioIn, sdaIn, sclIn}),
    .level_q(level)
  );
  assign sclF = level[0];
  assign sdaF = level[1];
  assign pinF = level[2];

  // Microsecond tick divider.
  logic [15:0] tickCnt_q, tickCnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = (tickCnt_q == 16'(TICK_CYCLES - 1));
    tickCnt_d = tick_d ? 16'h0000 : tickCnt_q + 16'h0001;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tickCnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tickCnt_q <= tickCnt_d;
      tick_q <= tick_d;
    end
  end

  // Register file.
  logic [15:0] vcfg_q, vcfg_d, tcfg_q, tcfg_d, regRead;
  logic oneShot_q, oneShot_d, softRst_q, softRst_d;
  logic gpioOut_d, gpioOe_d;
  logic wrStb_q, wrStb_d;
  logic [15:0] wrData_q, wrData_d;
  logic [7:0] ptr_q, ptr_d;

  always_comb begin
    regRead = 16'h0000;
    if (ptr_q == `VCFG_OFS) begin
      regRead = vcfg_q;
    end else if (ptr_q == `TCFG_OFS) begin
      regRead = tcfg_q;
      regRead[`TC_PIN_BIT] = pinF;
    end
  end

  always_comb begin
    vcfg_d = vcfg_q;
    tcfg_d = tcfg_q;
    oneShot_d = 1'b0;
    softRst_d = 1'b0;
    if (wrStb_q && ptr_q == `VCFG_OFS) begin
      if (wrData_q[`VC_RST_BIT]) begin
        vcfg_d = `VCFG_RST;
        tcfg_d = TCFG_RST;
        softRst_d = 1'b1;
      end else begin
        vcfg_d = wrData_q & `VCFG_WMASK;
        oneShot_d = wrData_q[`VC_ONESHOT_BIT];
      end
    end else if (wrStb_q && ptr_q == `TCFG_OFS) begin
      tcfg_d = wrData_q & `TCFG_WMASK;
      tcfg_d[`TC_RMT3_BIT] = wrData_q[`TC_RMT3_BIT] & THREE_CH;
    end
    gpioOe_d = tcfg_d[`TC_DRV_HI];
    gpioOut_d = tcfg_d[`TC_DRV_HI] & tcfg_d[`TC_DRV_LO];
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      vcfg_q <= `VCFG_RST;
      tcfg_q <= TCFG_RST;
      oneShot_q <= 1'b0;
      softRst_q <= 1'b0;
      gpioOe <= 1'b0;
      gpioOut <= 1'b0;
    end else begin
      vcfg_q <= vcfg_d;
      tcfg_q <= tcfg_d;
      oneShot_q <= oneShot_d;
      softRst_q <= softRst_d;
      gpioOe <= gpioOe_d;
      gpioOut <= gpioOut_d;
    end
  end

  assign busRangeSelect = vcfg_q[`VC_RANGE_BIT];
  assign gainSelect = vcfg_q[`VC_GAIN_HI:`VC_GAIN_LO];
  assign busSampleCfg = vcfg_q[`VC_BUS_HI:`VC_BUS_LO];
  assign shuntSampleCfg = vcfg_q[`VC_SHUNT_HI:`VC_SHUNT_LO];
  assign tempChannelOn = tcfg_q[`TC_RMT3_BIT:`TC_LOC_BIT];
  assign seriesResistanceFix = tcfg_q[`TC_SRF_BIT];

  // Serial slave: samples on the clock's rise, changes data after its fall.
  monitor_conversion_control_pkg::ser_state_e st_q, st_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] sh_q, sh_d, msb_q, msb_d, rdByte_q, rdByte_d, byteIn;
  logic [1:0] byteIdx_q, byteIdx_d;
  logic rw_q, rw_d, half_q, half_d, ackOn_q, ackOn_d, sdaOe_d;
  logic sclPrev_q, sdaPrev_q, sclRise, sclFall, startCond, stopCond;

  always_comb begin
    sclRise = sclF & ~sclPrev_q;
    sclFall = ~sclF & sclPrev_q;
    startCond = sclF & sclPrev_q & sdaPrev_q & ~sdaF;
    stopCond = sclF & sclPrev_q & ~sdaPrev_q & sdaF;
    byteIn = {sh_q[6:0], sdaF};
    st_d = st_q;
    bitCnt_d = bitCnt_q;
    sh_d = sh_q;
    msb_d = msb_q;
    rdByte_d = rdByte_q;
    byteIdx_d = byteIdx_q;
    rw_d = rw_q;
    half_d = half_q;
    ackOn_d = ackOn_q;
    sdaOe_d = sdaOe;
    ptr_d = ptr_q;
    wrStb_d = 1'b0;
    wrData_d = wrData_q;
    if (startCond) begin
      st_d = monitor_conversion_control_pkg::SER_ADDR;
      bitCnt_d = 3'h0;
      byteIdx_d = 2'h0;
      ackOn_d = 1'b0;
      sdaOe_d = 1'b0;
    end else if (stopCond) begin
      st_d = monitor_conversion_control_pkg::SER_IDLE;
      sdaOe_d = 1'b0;
    end else begin
      case (st_q)
        monitor_conversion_control_pkg::SER_ADDR: begin
          if (sclRise) begin
            sh_d = byteIn;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              rw_d = sdaF;
              st_d = (sh_q[6:0] == DEV_ADDR) ? monitor_conversion_control_pkg::SER_AACK
                                             : monitor_conversion_control_pkg::SER_IDLE;
            end
          end
        end
        monitor_conversion_control_pkg::SER_AACK,
        monitor_conversion_control_pkg::SER_WACK: begin
          if (sclFall) begin
            ackOn_d = ~ackOn_q;
            sdaOe_d = ~ackOn_q;
            bitCnt_d = 3'h0;
            if (ackOn_q && rw_q && st_q == monitor_conversion_control_pkg::SER_AACK) begin
              st_d = monitor_conversion_control_pkg::SER_RBYTE;
              rdByte_d = regRead[15:8];
              half_d = 1'b1;
              sdaOe_d = ~regRead[15];
            end else if (ackOn_q) begin
              st_d = monitor_conversion_control_pkg::SER_WBYTE;
            end
          end
        end
        monitor_conversion_control_pkg::SER_WBYTE: begin
          if (sclRise) begin
            sh_d = byteIn;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              st_d = monitor_conversion_control_pkg::SER_WACK;
              byteIdx_d = 2'h2;
              if (byteIdx_q == 2'h0) begin
                ptr_d = byteIn;
                byteIdx_d = 2'h1;
              end else if (byteIdx_q == 2'h1) begin
                msb_d = byteIn;
              end else begin
                wrStb_d = 1'b1;
                wrData_d = {msb_q, byteIn};
                byteIdx_d = 2'h1;
              end
            end
          end
        end
        monitor_conversion_control_pkg::SER_RBYTE: begin
          if (sclRise) begin
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              st_d = monitor_conversion_control_pkg::SER_RACK;
            end
          end else if (sclFall) begin
            sdaOe_d = ~rdByte_q[3'h7 - bitCnt_q];
          end
        end
        monitor_conversion_control_pkg::SER_RACK: begin
          if (sclFall) begin
            sdaOe_d = 1'b0;
          end else if (sclRise) begin
            if (!sdaF) begin
              st_d = monitor_conversion_control_pkg::SER_RBYTE;
              bitCnt_d = 3'h0;
              rdByte_d = half_q ? regRead[7:0] : regRead[15:8];
              half_d = ~half_q;
            end else begin
              st_d = monitor_conversion_control_pkg::SER_IDLE;
            end
          end
        end
        default: begin
          st_d = monitor_conversion_control_pkg::SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= monitor_conversion_control_pkg::SER_IDLE;
      bitCnt_q <= 3'h0;
      sh_q <= 8'h00;
      msb_q <= 8'h00;
      rdByte_q <= 8'h00;
      byteIdx_q <= 2'h0;
      rw_q <= 1'b0;
      half_q <= 1'b0;
      ackOn_q <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      ptr_q <= 8'h00;
      wrStb_q <= 1'b0;
      wrData_q <= 16'h0000;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      bitCnt_q <= bitCnt_d;
      sh_q <= sh_d;
      msb_q <= msb_d;
      rdByte_q <= rdByte_d;
      byteIdx_q <= byteIdx_d;
      rw_q <= rw_d;
      half_q <= half_d;
      ackOn_q <= ackOn_d;
      sdaOe <= sdaOe_d;
      sdaOut <= 1'b0;
      ptr_q <= ptr_d;
      wrStb_q <= wrStb_d;
      wrData_q <= wrData_d;
      sclPrev_q <= sclF;
      sdaPrev_q <= sdaF;
    end
  end

  // Conversion time of one four-bit sample field, in microseconds.
  function automatic logic [17:0] convUs(input logic [3:0] f);
    logic [17:0] t;
    t = `T12B_US;
    if (!f[3]) begin
      case (f[1:0])
        2'h0: t = `T9B_US;
        2'h1: t = `T10B_US;
        2'h2: t = `T11B_US;
        default: t = `T12B_US;
      endcase
    end else begin
      case (f[2:0])
        3'h1: t = `TAVG2_US;
        3'h2: t = `TAVG4_US;
        3'h3: t = `TAVG8_US;
        3'h4: t = `TAVG16_US;
        3'h5: t = `TAVG32_US;
        3'h6: t = `TAVG64_US;
        3'h7: t = `TAVG128_US;
        default: t = `T12B_US;
      endcase
    end
    return t;
  endfunction

  // Voltage core sequencer.
  monitor_conversion_control_pkg::volt_state_e vst_q, vst_d;
  logic [17:0] vTimer_q, vTimer_d, vLoad;
  logic voltDone_d, voltBusy_d, tempTrig_q, tempTrig_d;
  logic [2:0] mode;
  logic modeLoop, modeTrig;

  always_comb begin
    mode = vcfg_q[`VC_MODE_HI:`VC_MODE_LO];
    modeLoop = mode[2] & (mode[1:0] != 2'h0);
    modeTrig = ~mode[2] & (mode[1:0] != 2'h0);
    vLoad = (mode[0] ? convUs(shuntSampleCfg) : 18'h00000)
          + (mode[1] ? convUs(busSampleCfg) : 18'h00000);
    vst_d = vst_q;
    vTimer_d = vTimer_q;
    voltDone_d = 1'b0;
    case (vst_q)
      monitor_conversion_control_pkg::V_CONV: begin
        if (mode == `MODE_PD) begin
          vst_d = monitor_conversion_control_pkg::V_OFF;
        end else if (tick_q) begin
          vTimer_d = vTimer_q - 18'h00001;
          if (vTimer_q <= 18'h00001) begin
            voltDone_d = 1'b1;
            vTimer_d = vLoad;
            if (!modeLoop) begin
              vst_d = modeTrig ? monitor_conversion_control_pkg::V_IDLE
                               : monitor_conversion_control_pkg::V_OFF;
            end
          end
        end
      end
      default: begin
        vTimer_d = vLoad;
        if (modeLoop || (modeTrig && (oneShot_q || tempTrig_q))) begin
          vst_d = monitor_conversion_control_pkg::V_CONV;
        end else begin
          vst_d = modeTrig ? monitor_conversion_control_pkg::V_IDLE
                           : monitor_conversion_control_pkg::V_OFF;
        end
      end
    endcase
    voltBusy_d = (vst_d == monitor_conversion_control_pkg::V_CONV);
  end

  always_ff @(posedge mclk) begin
    if (!resetn || softRst_q) begin
      vst_q <= monitor_conversion_control_pkg::V_OFF;
      vTimer_q <= 18'h00000;
      voltDone <= 1'b0;
      voltBusy <= 1'b0;
    end else begin
      vst_q <= vst_d;
      vTimer_q <= vTimer_d;
      voltDone <= voltDone_d;
      voltBusy <= voltBusy_d;
    end
  end

  // Temperature core pacing.
  monitor_conversion_control_pkg::temp_state_e tst_q, tst_d;
  logic [23:0] tTimer_q, tTimer_d, tPeriod;
  logic [2:0] rate, nCh;
  logic anyEn, rpt, tempDone_d, tempBusy_d;

  always_comb begin
    rate = tcfg_q[`TC_RATE_HI:`TC_RATE_LO];
    rpt = tcfg_q[`TC_REPEAT_BIT];
    anyEn = (tempChannelOn != 4'h0);
    nCh = 3'(tempChannelOn[0]) + 3'(tempChannelOn[1])
        + 3'(tempChannelOn[2]) + 3'(tempChannelOn[3]);
    tPeriod = `RATE2_US << (3'h5 - rate);
    if (rate == `RATE_HALF) begin
      tPeriod = (nCh <= 3'h2) ? `RATE4_US : (nCh == 3'h3) ? `RATE3_US : `RATE2_US;
    end else if (rate == `RATE_FAST) begin
      tPeriod = (nCh <= 3'h1) ? `RATE8_US : (nCh == 3'h2) ? `RATE4_US : `RATE3_US;
    end
    tst_d = tst_q;
    tTimer_d = tTimer_q;
    tempDone_d = 1'b0;
    tempTrig_d = 1'b0;
    case (tst_q)
      monitor_conversion_control_pkg::T_RUN: begin
        if (!rpt && !anyEn) begin
          tst_d = monitor_conversion_control_pkg::T_OFF;
        end else if (tick_q) begin
          tTimer_d = tTimer_q - 24'h000001;
          if (tTimer_q <= 24'h000001) begin
            tempDone_d = anyEn;
            tempTrig_d = (rate != `RATE_FAST) & anyEn & modeTrig;
            tTimer_d = tPeriod;
            if (!rpt) begin
              tst_d = monitor_conversion_control_pkg::T_OFF;
            end
          end
        end
      end
      default: begin
        tTimer_d = tPeriod;
        if (rpt || (oneShot_q && anyEn)) begin
          tst_d = monitor_conversion_control_pkg::T_RUN;
        end
      end
    endcase
    tempBusy_d = (tst_d == monitor_conversion_control_pkg::T_RUN) & anyEn;
  end

  always_ff @(posedge mclk) begin
    if (!resetn || softRst_q) begin
      tst_q <= monitor_conversion_control_pkg::T_OFF;
      tTimer_q <= 24'h000000;
      tempTrig_q <= 1'b0;
      tempDone <= 1'b0;
      tempBusy <= 1'b0;
    end else begin
      tst_q <= tst_d;
      tTimer_q <= tTimer_d;
      tempTrig_q <= tempTrig_d;
      tempDone <= tempDone_d;
      tempBusy <= tempBusy_d;
    end
  end
endmodule // monitor_conversion_control
`default_nettype wire

// ==== monitor_conversion_control_properties.sv ====
`default_nettype none
module monitor_conversion_control_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Serial link and pin
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic gpioIn,
  input wire logic gpioOut,
  input wire logic gpioOe,
  // Core controls
  input wire logic busRangeSelect,
  input wire logic [1:0] gainSelect,
  input wire logic [3:0] busSampleCfg,
  input wire logic [3:0] shuntSampleCfg,
  input wire logic voltBusy,
  input wire logic voltDone,
  input wire logic [3:0] tempChannelOn,
  input wire logic seriesResistanceFix,
  input wire logic tempBusy,
  input wire logic tempDone
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  reset_values_a: assert property (
    $rose(resetn) |-> !voltBusy && !tempBusy && !sdaOe && !gpioOe && busRangeSelect
    && gainSelect == 2'h3 && busSampleCfg == 4'h3 && shuntSampleCfg == 4'h3
    && tempChannelOn == 4'hf && seriesResistanceFix) else $error("outputs not at defaults");
  volt_start_a: assert property ($rose(resetn) |-> ##[1:3] voltBusy)
    else $error("default continuous mode did not start");
  temp_start_a: assert property ($rose(resetn) |-> ##[1:3] tempBusy)
    else $error("default temperature run did not start");
  done_follows_busy_a: assert property (voltDone |-> $past(voltBusy))
    else $error("conversion end without a running conversion");
  volt_pulse_a: assert property (voltDone |=> !voltDone)
    else $error("conversion end pulse too long");
  temp_pulse_a: assert property (tempDone |=> !tempDone)
    else $error("pass end pulse too long");
  open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  gpio_drive_a: assert property (gpioOut |-> gpioOe)
    else $error("pin level without drive enable");
  sda_timing_a: assert property (
    $changed(sdaOe) |-> !sclIn && $past(!sclIn, 2)) else $error("data changed while clock high");
  cfg_update_a: assert property (
    $changed({busRangeSelect, gainSelect, busSampleCfg, shuntSampleCfg, gpioOe})
    |-> sclIn) else $error("configuration changed outside a byte end");
endmodule // monitor_conversion_control_checker
bind monitor_conversion_control monitor_conversion_control_checker i_chk (.mclk(mclk),
  .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .busRangeSelect(busRangeSelect),
  .gainSelect(gainSelect), .busSampleCfg(busSampleCfg), .shuntSampleCfg(shuntSampleCfg),
  .voltBusy(voltBusy), .voltDone(voltDone), .tempChannelOn(tempChannelOn),
  .seriesResistanceFix(seriesResistanceFix), .tempBusy(tempBusy), .tempDone(tempDone));
`default_nettype wire

// ==== serial_host_model.sv ====
`default_nettype none
module serial_host_model (
  // Clock
  input wire logic mclk,
  // Two-wire lines
  input wire logic sdaWire,
  output var logic sclIn,
  output var logic sdaPull
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclIn = 1'b1;
    sdaPull = 1'b0;
  end
  // Data moves well inside the low phase, so the device never sees it race the clock.
  task automatic bitCycle(input logic b, output logic s);
    repeat (4) @(posedge mclk);
    sdaPull <= ~b;
    repeat (6) @(posedge mclk);
    sclIn <= 1'b1;
    repeat (10) @(posedge mclk);
    s = sdaWire;
    sclIn <= 1'b0;
  endtask
  task automatic startBit();
    sdaPull <= 1'b1;
    repeat (10) @(posedge mclk);
    sclIn <= 1'b0;
  endtask
  task automatic stopBit();
    repeat (4) @(posedge mclk);
    sdaPull <= 1'b1;
    repeat (6) @(posedge mclk);
    sclIn <= 1'b1;
    repeat (10) @(posedge mclk);
    sdaPull <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(d[i], s);
    bitCycle(1'b1, s);
    ack = !s;
  endtask
  task automatic recvByte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(1'b1, d[i]);
    bitCycle(last, s);
  endtask
  task automatic writeReg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v,
                          output logic ok);
    logic k0, k1, k2, k3;
    startBit();
    sendByte({a, 1'b0}, k0);
    sendByte(p, k1);
    sendByte(v[15:8], k2);
    sendByte(v[7:0], k3);
    stopBit();
    ok = k0 & k1 & k2 & k3;
  endtask
  task automatic readReg(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v,
                         output logic ok);
    logic k0, k1, k2;
    startBit();
    sendByte({a, 1'b0}, k0);
    sendByte(p, k1);
    stopBit();
    startBit();
    sendByte({a, 1'b1}, k2);
    recvByte(1'b0, v[15:8]);
    recvByte(1'b1, v[7:0]);
    stopBit();
    ok = k0 & k1 & k2;
  endtask
endmodule // serial_host_model
`default_nettype wire

// ==== monitor_conversion_control_tb.sv ====
`default_nettype none
module monitor_conversion_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = 7'h5c;
  localparam int LIMIT = 80000;
  logic mclk, resetn, sdaIn, sclIn, sdaPull, sdaOut, sdaOe, gpioIn, gpioOut, gpioOe;
  logic busRangeSelect, voltBusy, voltDone, seriesResistanceFix, tempBusy, tempDone;
  logic extLevel, busyPrev, ok;
  logic [1:0] gainSelect;
  logic [3:0] busSampleCfg, shuntSampleCfg, tempChannelOn;
  logic [15:0] cfgs [6] = '{16'h6001, 16'h6021, 16'h6041, 16'h6049, 16'h6082, 16'h6083};
  int lens [6] = '{105, 105, 665, 1300, 185, 290};
  int nMismatch, nTests, cycles, riseAt, doneAt;
  // The data wire has a pull-up; the pin sees the external level unless driven.
  assign sdaIn = !(sdaPull || (sdaOe && !sdaOut));
  assign gpioIn = gpioOe ? gpioOut : extLevel;
  monitor_conversion_control #(.DEV_ADDR(ADDR), .THREE_CH(1'b1), .TICK_CYCLES(1))
    i_monitor_conversion_control (.mclk(mclk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .busRangeSelect(busRangeSelect), .gainSelect(gainSelect), .busSampleCfg(busSampleCfg),
    .shuntSampleCfg(shuntSampleCfg), .voltBusy(voltBusy), .voltDone(voltDone),
    .tempChannelOn(tempChannelOn), .seriesResistanceFix(seriesResistanceFix),
    .tempBusy(tempBusy), .tempDone(tempDone));
  serial_host_model i_serial_host_model (.mclk(mclk), .sdaWire(sdaIn), .sclIn(sclIn),
    .sdaPull(sdaPull));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("tests %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (voltBusy === 1'b1 && busyPrev !== 1'b1) riseAt = cycles;
    if (voltDone === 1'b1) doneAt = cycles;
    busyPrev = voltBusy;
    if (cycles == LIMIT) begin
      nMismatch++;
      $display("Error at %0t: run timed out", $time);
      conclude();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    i_serial_host_model.writeReg(ADDR, p, v, ok);
    check(16'(ok), 16'h1, "write acknowledge");
  endtask
  task automatic checkReg(input logic [7:0] p, input logic [15:0] exp, input string what);
    logic [15:0] v;
    i_serial_host_model.readReg(ADDR, p, v, ok);
    check(16'(ok), 16'h1, "read acknowledge");
    check(v, exp, what);
  endtask
  // A conversion that started before this call is accepted only if it ends after it.
  task automatic waitDone(input int n);
    int start;
    start = cycles;
    while (doneAt < start && cycles - start < n) @(posedge mclk);
    check(16'(doneAt >= start), 16'h1, "conversion end seen");
  endtask
  task automatic testDefaults();
    checkReg(8'h00, 16'h399f, "voltage cfg");
    checkReg(8'h01, 16'hff80, "temp cfg");
    check(16'({busRangeSelect, gainSelect, busSampleCfg, shuntSampleCfg}), 16'h0733, "vf");
    check(16'({tempChannelOn, seriesResistanceFix}), 16'h001f, "temp fields");
    $display("testDefaults done");
  endtask
  task automatic testFields();
    wr(8'h00, 16'h1234);
    check(16'(voltBusy), 16'h1, "busy after mode 100");
    check(16'({busRangeSelect, gainSelect, busSampleCfg, shuntSampleCfg}), 16'h0246, "vf");
    waitDone(3000);
    repeat (200) @(posedge mclk);
    check(16'(voltBusy), 16'h0, "converter off");
    checkReg(8'h00, 16'h1234, "voltage readback");
    $display("testFields done");
  endtask
  task automatic testHalt();
    wr(8'h00, 16'h3fff);
    check(16'(voltBusy), 16'h1, "continuous run");
    wr(8'h00, 16'h3ff8);
    check(16'(voltBusy), 16'h0, "halted at once");
    $display("testHalt done");
  endtask
  task automatic testTriggered();
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, cfgs[i] & 16'hbfff);
      check(16'(voltBusy), 16'h0, "idle in triggered mode");
      wr(8'h00, cfgs[i]);
      waitDone(2000);
      check(16'(doneAt - riseAt >= lens[i] - 2 && doneAt - riseAt <= lens[i] + 1), 16'h1,
            "conversion time");
    end
    checkReg(8'h00, 16'h2083, "one-shot reads zero");
    $display("testTriggered done");
  endtask
  task automatic testTemp();
    logic pin;
    wr(8'h01, 16'h0000);
    check(16'(tempBusy), 16'h0, "stop with no channel");
    check(16'({tempChannelOn, seriesResistanceFix}), 16'h0, "temp fields");
    wr(8'h01, 16'h8800);
    check(16'(tempBusy), 16'h1, "continuous start");
    wr(8'h01, 16'h0800);
    check(16'(tempBusy), 16'h1, "pass finishes");
    wr(8'h01, 16'h0000);
    check(16'(tempBusy), 16'h0, "immediate stop");
    wr(8'h01, 16'h0800);
    check(16'(tempBusy), 16'h0, "no pass without trigger");
    wr(8'h00, 16'h799c);
    check(16'(tempBusy), 16'h1, "one-shot pass");
    extLevel <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h01, 16'h0778 | 16'(c));
      pin = (c >= 2) ? c[0] : 1'b1;
      check(16'({gpioOe, gpioOut}), 16'({c[1], c == 3}), "pin drive");
      checkReg(8'h01, 16'h0700 | 16'(c) | 16'({pin, 2'b00}), "pin readback");
    end
    $display("testTemp done");
  endtask
  task automatic testSoftReset();
    wr(8'h00, 16'h8000);
    checkReg(8'h00, 16'h399f, "voltage cfg");
    checkReg(8'h01, 16'hff84, "temp cfg");
    check(16'(tempBusy), 16'h1, "temperature restart");
    $display("testSoftReset done");
  endtask
  task automatic testRefused();
    i_serial_host_model.writeReg(7'h5d, 8'h00, 16'h0000, ok);
    check(16'(ok), 16'h0, "foreign address");
    wr(8'h05, 16'hbeef);
    checkReg(8'h05, 16'h0000, "unmapped pointer");
    checkReg(8'h00, 16'h399f, "untouched by foreign");
    $display("testRefused done");
  endtask
  initial begin
    resetn = 1'b0;
    extLevel = 1'b0;
    busyPrev = 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    testDefaults();
    testFields();
    testHalt();
    testTriggered();
    testTemp();
    testSoftReset();
    testRefused();
    conclude();
  end
endmodule // monitor_conversion_control_tb
`default_nettype wire
